// ### design/timer_pkg.sv
// package: register map, field positions and types for the basic up-count timer
package timer_pkg;
	localparam logic [5:0] off_control = 6'h00;
	localparam logic [5:0] off_enable = 6'h0c;
	localparam logic [5:0] off_status = 6'h10;
	localparam logic [5:0] off_event = 6'h14;
	localparam logic [5:0] off_count = 6'h24;
	localparam logic [5:0] off_prescale = 6'h28;
	localparam logic [5:0] off_reload = 6'h2c;
	localparam logic [5:0] off_trigger_mode = 6'h30;
	localparam int bit_run = 0;
	localparam int bit_block = 1;
	localparam int bit_source = 2;
	localparam int bit_one_shot = 3;
	localparam int bit_buffer = 7;
	localparam int bit_irq_en = 0;
	localparam int bit_dma_en = 8;
	localparam int bit_flag = 0;
	localparam int bit_force = 0;
	localparam logic [15:0] control_mask = 16'h008f;
	localparam logic [15:0] enable_mask = 16'h0101;
	localparam logic [15:0] control_reset = 16'h0000;
	localparam logic [15:0] enable_reset = 16'h0000;
	localparam logic [15:0] count_reset = 16'h0000;
	localparam logic [15:0] prescale_reset = 16'h0000;
	localparam logic [15:0] reload_reset = 16'hffff;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	typedef struct packed {
		logic buffer;
		logic one_shot;
		logic source;
		logic block;
		logic run;
	} control_t;
endpackage : timer_pkg

// ### design/basic_upcount_timer.sv
// module: basic 16-bit up-count timer with axi4-lite register slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module basic_upcount_timer (
	input wire logic clock,
	input wire logic reset,
	input wire logic trigger_start,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	output logic dma_request
);
	timer_pkg::control_t control_q;
	logic [15:0] enable_q;
	logic flag_q;
	logic trigger_mode_q;
	logic [15:0] count_q;
	logic [15:0] prescale_q;
	logic [15:0] prescale_active_q;
	logic [15:0] prescale_count_q;
	logic [15:0] reload_q;
	logic [15:0] reload_active_q;
	logic [1:0] trig_sync_q;
	logic trig_last_q;
	logic [5:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_held_q;
	logic w_held_q;
	logic write_fire;
	logic [15:0] wval;
	logic tick;
	logic overflow;
	logic force_upd;
	logic update_event;
	logic request;
	logic dma_q;
	logic trigger_rise;

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign write_fire = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wval = wdata_q[15:0] & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

	// write channel capture; address and data in either order
	always_ff @(posedge clock) begin
		if (reset) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 6'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (write_fire) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (write_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= timer_pkg::resp_okay;
		end else if (write_fire) begin
			s_axi_bvalid <= 1'b1;
			case (awaddr_q & 6'h3c)
				timer_pkg::off_control, timer_pkg::off_enable, timer_pkg::off_status,
				timer_pkg::off_event, timer_pkg::off_count, timer_pkg::off_prescale,
				timer_pkg::off_reload, timer_pkg::off_trigger_mode:
					s_axi_bresp <= timer_pkg::resp_okay;
				default: s_axi_bresp <= timer_pkg::resp_slverr;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	function automatic logic wr_to(input logic [5:0] off);
		wr_to = write_fire && ((awaddr_q & 6'h3c) == off);
	endfunction : wr_to

	// trigger input passes two flip-flops before use
	always_ff @(posedge clock) begin
		if (reset) begin
			trig_sync_q <= 2'h0;
			trig_last_q <= 1'b0;
		end else begin
			trig_sync_q <= {trig_sync_q[0], trigger_start};
			trig_last_q <= trig_sync_q[1];
		end
	end
	assign trigger_rise = trig_sync_q[1] && !trig_last_q && trigger_mode_q;

	assign force_upd = wr_to(timer_pkg::off_event) && wval[timer_pkg::bit_force];
	// prescaler divides by active value plus one
	assign tick = control_q.run && (prescale_count_q == prescale_active_q);
	assign overflow = tick && (reload_active_q != 16'h0000)
		&& (count_q == reload_active_q);
	assign update_event = !control_q.block && (overflow || force_upd);
	assign request = update_event && (overflow || !control_q.source);

	always_ff @(posedge clock) begin
		if (reset) begin
			control_q <= timer_pkg::control_t'(timer_pkg::control_reset[4:0]);
		end else begin
			if (wr_to(timer_pkg::off_control)) begin
				control_q.run <= wval[timer_pkg::bit_run];
				control_q.block <= wval[timer_pkg::bit_block];
				control_q.source <= wval[timer_pkg::bit_source];
				control_q.one_shot <= wval[timer_pkg::bit_one_shot];
				control_q.buffer <= wval[timer_pkg::bit_buffer];
			end else if (trigger_rise) begin
				control_q.run <= 1'b1;
			end
			if (update_event && control_q.one_shot) begin
				control_q.run <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			enable_q <= timer_pkg::enable_reset;
			trigger_mode_q <= 1'b0;
		end else begin
			if (wr_to(timer_pkg::off_enable)) begin
				enable_q <= wval & timer_pkg::enable_mask;
			end
			if (wr_to(timer_pkg::off_trigger_mode)) begin
				trigger_mode_q <= wval[0];
			end
		end
	end

	// update flag: hardware set wins over the software clear
	always_ff @(posedge clock) begin
		if (reset) begin
			flag_q <= 1'b0;
		end else if (request) begin
			flag_q <= 1'b1;
		end else if (wr_to(timer_pkg::off_status) && !wval[timer_pkg::bit_flag]
			&& wstrb_q[0]) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			dma_q <= 1'b0;
		end else begin
			dma_q <= request && enable_q[timer_pkg::bit_dma_en];
		end
	end
	assign dma_request = dma_q;
	assign irq = flag_q && enable_q[timer_pkg::bit_irq_en];

	always_ff @(posedge clock) begin
		if (reset) begin
			prescale_count_q <= 16'h0000;
		end else if (force_upd || tick) begin
			prescale_count_q <= 16'h0000;
		end else if (control_q.run) begin
			prescale_count_q <= prescale_count_q + 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			count_q <= timer_pkg::count_reset;
		end else if (force_upd) begin
			count_q <= 16'h0000;
		end else if (wr_to(timer_pkg::off_count)) begin
			count_q <= wval;
		end else if (overflow) begin
			count_q <= 16'h0000;
		end else if (tick && reload_active_q != 16'h0000) begin
			count_q <= count_q + 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			prescale_q <= timer_pkg::prescale_reset;
			prescale_active_q <= timer_pkg::prescale_reset;
			reload_q <= timer_pkg::reload_reset;
			reload_active_q <= timer_pkg::reload_reset;
		end else begin
			if (wr_to(timer_pkg::off_prescale)) begin
				prescale_q <= wval;
			end
			if (wr_to(timer_pkg::off_reload)) begin
				reload_q <= wval;
			end
			if (update_event) begin
				prescale_active_q <= prescale_q;
				reload_active_q <= reload_q;
			end
			if (wr_to(timer_pkg::off_reload) && !control_q.buffer) begin
				reload_active_q <= wval;
			end
		end
	end

	// read channel
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clock) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= timer_pkg::resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= timer_pkg::resp_okay;
			case (s_axi_araddr & 6'h3c)
				timer_pkg::off_control: s_axi_rdata <= {24'h000000, control_q.buffer,
					3'h0, control_q.one_shot, control_q.source, control_q.block,
					control_q.run};
				timer_pkg::off_enable: s_axi_rdata <= {16'h0000, enable_q};
				timer_pkg::off_status: s_axi_rdata <= {31'h00000000, flag_q};
				timer_pkg::off_event: s_axi_rdata <= 32'h00000000;
				timer_pkg::off_count: s_axi_rdata <= {16'h0000, count_q};
				timer_pkg::off_prescale: s_axi_rdata <= {16'h0000, prescale_q};
				timer_pkg::off_reload: s_axi_rdata <= {16'h0000, reload_q};
				timer_pkg::off_trigger_mode: s_axi_rdata <= {31'h00000000, trigger_mode_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= timer_pkg::resp_slverr;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	overflow_wraps_a: assert property (@(posedge clock) disable iff (reset)
		overflow && !force_upd && !wr_to(timer_pkg::off_count) |=> count_q == 16'h0000)
		else $error("counter did not wrap");
	zero_reload_holds_a: assert property (@(posedge clock) disable iff (reset)
		reload_active_q == 16'h0000 && !force_upd && !wr_to(timer_pkg::off_count)
		|=> $stable(count_q)) else $error("counter moved with zero reload");
	block_stops_update_a: assert property (@(posedge clock) disable iff (reset)
		control_q.block |-> !update_event) else $error("update not blocked");
	source_filter_a: assert property (@(posedge clock) disable iff (reset)
		control_q.source && force_upd && !overflow && !flag_q |=> !flag_q)
		else $error("force update raised request");
	one_shot_stop_a: assert property (@(posedge clock) disable iff (reset)
		update_event && control_q.one_shot |=> !control_q.run)
		else $error("one shot did not stop");
	flag_set_a: assert property (@(posedge clock) disable iff (reset)
		request |=> flag_q) else $error("update flag not set");
	stopped_count_a: assert property (@(posedge clock) disable iff (reset)
		!control_q.run && !force_upd && !wr_to(timer_pkg::off_count) |=> $stable(count_q))
		else $error("counter moved while stopped");
	reload_copy_a: assert property (@(posedge clock) disable iff (reset)
		update_event && !wr_to(timer_pkg::off_reload) |=> reload_active_q == $past(reload_q))
		else $error("reload not transferred");
	force_clear_a: assert property (@(posedge clock) disable iff (reset)
		force_upd |=> count_q == 16'h0000 && prescale_count_q == 16'h0000)
		else $error("force update did not clear");

	// reset leaves registers at their documented values
	reset_values_a: assert property (@(posedge clock) reset |=>
		control_q == timer_pkg::control_reset[4:0] && count_q == timer_pkg::count_reset
		&& reload_q == timer_pkg::reload_reset && !flag_q) else $error("bad reset values");

	// counting steps
	count_step_a: assert property (@(posedge clock) disable iff (reset)
		tick && reload_active_q != 16'h0000 && count_q != reload_active_q && !force_upd
		&& !wr_to(timer_pkg::off_count) |=> count_q == $past(count_q) + 16'h0001)
		else $error("counter did not step by one");
	prescale_bound_a: assert property (@(posedge clock) disable iff (reset)
		prescale_count_q <= prescale_active_q) else $error("prescale count overran");
	stopped_prescale_a: assert property (@(posedge clock) disable iff (reset)
		!control_q.run && !force_upd |=> $stable(prescale_count_q))
		else $error("prescaler moved while stopped");
	prescale_copy_a: assert property (@(posedge clock) disable iff (reset)
		update_event |=> prescale_active_q == $past(prescale_q))
		else $error("prescale not transferred");
	reload_now_a: assert property (@(posedge clock) disable iff (reset)
		!control_q.buffer && wr_to(timer_pkg::off_reload) |=> reload_active_q == $past(wval))
		else $error("unbuffered reload not immediate");
	reload_held_a: assert property (@(posedge clock) disable iff (reset)
		control_q.buffer && wr_to(timer_pkg::off_reload) && !update_event
		|=> $stable(reload_active_q)) else $error("buffered reload applied early");
	trigger_run_a: assert property (@(posedge clock) disable iff (reset)
		trigger_rise && !wr_to(timer_pkg::off_control)
		&& !(update_event && control_q.one_shot) |=> control_q.run)
		else $error("trigger did not start counter");

	// update requests and their outputs
	sequence forced_update_s;
		force_upd && !control_q.block && !control_q.source;
	endsequence
	sequence flag_raised_s;
		flag_q;
	endsequence
	force_flag_a: assert property (@(posedge clock) disable iff (reset)
		forced_update_s |=> flag_raised_s) else $error("force update did not flag");
	overflow_request_a: assert property (@(posedge clock) disable iff (reset)
		overflow && !control_q.block |-> request) else $error("overflow gave no request");
	flag_clear_a: assert property (@(posedge clock) disable iff (reset)
		wr_to(timer_pkg::off_status) && wstrb_q[0] && !wval[timer_pkg::bit_flag] && !request
		|=> !flag_q) else $error("update flag not cleared");
	irq_raise_a: assert property (@(posedge clock) disable iff (reset)
		request && enable_q[timer_pkg::bit_irq_en] |=> irq) else $error("irq not raised");
	dma_pulse_a: assert property (@(posedge clock) disable iff (reset)
		request && enable_q[timer_pkg::bit_dma_en] |=> dma_request)
		else $error("dma request missing");
	dma_quiet_a: assert property (@(posedge clock) disable iff (reset)
		!request |=> !dma_request) else $error("dma request without update");
	enable_reserved_a: assert property (@(posedge clock) disable iff (reset)
		(enable_q & ~timer_pkg::enable_mask) == 16'h0000)
		else $error("reserved enable bit set");

	// register bus handshakes
	sequence both_halves_held_s;
		aw_held_q && w_held_q && !s_axi_bvalid;
	endsequence
	sequence response_raised_s;
		s_axi_bvalid;
	endsequence
	write_response_a: assert property (@(posedge clock) disable iff (reset)
		both_halves_held_s |=> response_raised_s) else $error("write response missing");
	write_busy_a: assert property (@(posedge clock) disable iff (reset)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while responding");
	read_response_a: assert property (@(posedge clock) disable iff (reset)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response missing");
	read_busy_a: assert property (@(posedge clock) disable iff (reset)
		s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while responding");
endmodule : basic_upcount_timer

// ### tb/tb_top.sv
// testbench: register-level checks of the basic up-count timer
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic trigger_start = 1'b0;
	logic [5:0] s_axi_awaddr = 6'h00;
	logic [5:0] s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rdv;
	logic irq, dma_request;
	int n_mismatch = 0;
	int num_checks = 0;
	int dma_n = 0;
	basic_upcount_timer DUT (.clock(clock), .reset(reset), .trigger_start(trigger_start),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
		.dma_request(dma_request));
	initial begin
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		if (dma_request === 1'b1) dma_n <= dma_n + 1;
	end
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task step(inout int n);
		@(posedge clock);
		n++;
		if (n > 200) begin
			n_mismatch++;
			$display("BAD %0t bus wait ran out", $time);
			test_done();
		end
	endtask : step
	task wr(input logic [5:0] a, input logic [15:0] d);
		int n;
		logic aw_ok, w_ok;
		n = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'h3;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			step(n);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do step(n); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [5:0] a);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do step(n); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do step(n); while (s_axi_rvalid !== 1'b1);
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task rchk(input logic [5:0] a, input logic [31:0] exp, input string what);
		rd(a);
		chk(rdv, exp, what);
	endtask : rchk
	task wait_irq(input int lim, input logic exp, input string what);
		int n;
		for (n = 0; n < lim && irq !== 1'b1; n++) @(posedge clock);
		chk({31'h0, irq}, {31'h0, exp}, what);
	endtask : wait_irq
	initial begin
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		rchk(timer_pkg::off_control, 32'h0, "control reset");
		rchk(timer_pkg::off_enable, 32'h0, "enable reset");
		rchk(timer_pkg::off_status, 32'h0, "status reset");
		rchk(timer_pkg::off_count, 32'h0, "count reset");
		rchk(timer_pkg::off_prescale, 32'h0, "prescale reset");
		rchk(timer_pkg::off_reload, 32'h0000ffff, "reload reset");
		rd(6'h18);
		chk({30'h0, rsp}, {30'h0, timer_pkg::resp_slverr}, "unmapped resp");
		wr(6'h18, 16'h0001);
		chk({30'h0, rsp}, {30'h0, timer_pkg::resp_slverr}, "unmapped write resp");
		wr(timer_pkg::off_enable, 16'hffff);
		chk({30'h0, rsp}, {30'h0, timer_pkg::resp_okay}, "mapped write resp");
		rchk(timer_pkg::off_enable, 32'h0101, "enable bits");
		wr(timer_pkg::off_control, 16'hfff2);
		rchk(timer_pkg::off_control, 32'h0082, "control bits");
		$display("test registers done");
		wr(timer_pkg::off_control, 16'h0000);
		wr(timer_pkg::off_reload, 16'h0005);
		wr(timer_pkg::off_control, 16'h0001);
		wait_irq(40, 1'b1, "overflow irq");
		rd(timer_pkg::off_count);
		chk({31'h0, rdv <= 32'h5}, 32'h1, "count range");
		chk({31'h0, dma_n > 0}, 32'h1, "dma pulse");
		wr(timer_pkg::off_control, 16'h0000);
		wr(timer_pkg::off_status, 16'h0000);
		wait_irq(1, 1'b0, "flag cleared");
		$display("test overflow done");
		wr(timer_pkg::off_count, 16'h0003);
		wr(timer_pkg::off_control, 16'h0004);
		wr(timer_pkg::off_event, 16'h0001);
		wait_irq(10, 1'b0, "source select");
		rchk(timer_pkg::off_count, 32'h0, "force clears count");
		wr(timer_pkg::off_control, 16'h0002);
		wr(timer_pkg::off_event, 16'h0001);
		wait_irq(10, 1'b0, "update blocked");
		wr(timer_pkg::off_control, 16'h0000);
		wr(timer_pkg::off_event, 16'h0001);
		wait_irq(10, 1'b1, "force irq");
		wr(timer_pkg::off_status, 16'h0000);
		$display("test force done");
		wr(timer_pkg::off_control, 16'h0080);
		wr(timer_pkg::off_reload, 16'h0014);
		rchk(timer_pkg::off_reload, 32'h14, "reload readback");
		wr(timer_pkg::off_count, 16'h0000);
		wr(timer_pkg::off_control, 16'h0089);
		wait_irq(15, 1'b1, "old limit kept");
		rchk(timer_pkg::off_control, 32'h0088, "one shot stop");
		wr(timer_pkg::off_status, 16'h0000);
		$display("test one shot done");
		wr(timer_pkg::off_control, 16'h0004);
		wr(timer_pkg::off_prescale, 16'h0003);
		rchk(timer_pkg::off_prescale, 32'h3, "prescale readback");
		wr(timer_pkg::off_reload, 16'h0005);
		wr(timer_pkg::off_event, 16'h0001);
		wr(timer_pkg::off_control, 16'h0001);
		wait_irq(16, 1'b0, "divided early");
		wait_irq(20, 1'b1, "divided overflow");
		wr(timer_pkg::off_control, 16'h0000);
		wr(timer_pkg::off_status, 16'h0000);
		wr(timer_pkg::off_reload, 16'h0000);
		wr(timer_pkg::off_count, 16'h0000);
		wr(timer_pkg::off_control, 16'h0001);
		wait_irq(40, 1'b0, "zero limit");
		rchk(timer_pkg::off_count, 32'h0, "zero limit count");
		wr(timer_pkg::off_control, 16'h0000);
		$display("test prescale done");
		wr(timer_pkg::off_trigger_mode, 16'h0001);
		trigger_start <= 1'b1;
		repeat (4) @(posedge clock);
		rchk(timer_pkg::off_control, 32'h1, "trigger start");
		$display("test trigger done");
		test_done();
	end
endmodule : tb_top
